// ==== src/nvc_array.v ====
`timescale 1ns/1ps
`include "nvc_defines.vh"
module nvc_array #(
    parameter AW = 8
) (
    input  wire          ref_clk_in,   // system clock
    input  wire          we_in,        // write one byte
    input  wire [AW-1:0] waddr_in,     // write byte address
    input  wire [7:0]    wdata_in,     // write byte
    input  wire [AW-1:0] raddr_in,     // read byte address
    output wire [7:0]    rdata_out     // combinational read byte
);
    reg [7:0] mem [0:(1<<AW)-1];

    always @(posedge ref_clk_in) begin
        if (we_in) begin
            mem[waddr_in] <= wdata_in;
        end
    end

    assign rdata_out = mem[raddr_in];
endmodule

// ==== src/nvc_ctrl.v ====
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "nvc_defines.vh"
module nvc_ctrl #(
    parameter        AW        = 8,
    parameter [31:0] PWRT_CYC  = `NVC_PWRT_CYC,
    parameter [31:0] WRITE_CYC = `NVC_WRITE_CYC,
    parameter [13:0] DEV_ID    = 14'h1234, // arbitrary value
    parameter [13:0] CFG_WORD1 = 14'h3FFF,
    parameter [13:0] CFG_WORD2 = 14'h3FFF
) (
    input  wire        ref_clk_in,       // 100 MHz clock
    input  wire        srst_in,          // sync reset, active high
    input  wire        hsel_in,          // ahb select
    input  wire [31:0] haddr_in,         // ahb address
    input  wire [1:0]  htrans_in,        // ahb transfer type
    input  wire        hwrite_in,        // ahb write
    input  wire [2:0]  hsize_in,         // ahb size
    input  wire [31:0] hwdata_in,        // ahb write data
    input  wire        hready_in,        // ahb bus ready
    output reg  [31:0] hrdata_out,       // ahb read data
    output reg         hreadyout_out,    // ahb slave ready
    output reg         hresp_out,        // ahb response, always okay
    input  wire        data_protect_fuse_in, // 0 = data protected
    input  wire        ext_rd_in,        // external programmer read
    input  wire [AW-1:0] ext_addr_in,    // external programmer address
    output reg  [7:0]  ext_data_out,     // external read byte
    output reg         write_done_out    // done flag level
);
    reg [AW-1:0] adr_low_ff;
    reg [7:0]  adr_high_ff, dat_low_ff, dat_high_ff;
    reg        rd_ff, wr_ff, write_enable_latch_ff, config_space_select_ff, pgs_ff, done_ff;
    reg [1:0]  key_ff;
    reg [31:0] pwrt_ff, wcnt_ff;
    reg [AW-1:0] wadr_ff;
    reg [7:0]  wdat_ff;
    reg        ap_ff, aw_ff;
    reg [7:0]  aa_ff;
    reg [13:0] uid_ff [0:3];
    reg        fuse_s1_ff, fuse_ff, erd_s1_ff, erd_ff;
    reg [AW-1:0] eadr_s1_ff, eadr_ff;
    wire [7:0] arr_q, reg_q;
    wire       we_arr;
    reg  [13:0] cfg_q;
    reg        cfg_ok;
    wire       bus_take, bus_wr, unlk_wr, ctl_wr, dl_wr;
    wire       start_wr, done_now, cfg_wr_ok;

    assign bus_take = hsel_in & htrans_in[1] & hready_in;
    assign bus_wr   = aw_ff & ap_ff;
    assign unlk_wr  = bus_wr & (aa_ff == `NVC_OFS_UNLOCK);
    assign ctl_wr   = bus_wr & (aa_ff == `NVC_OFS_CONTROL);
    assign dl_wr    = bus_wr & (aa_ff == `NVC_OFS_DATA_LOW);
    // strobe accepted only after full key, with latch set, after timer
    assign start_wr = ctl_wr & hwdata_in[`NVC_BIT_WR] & ~wr_ff & (key_ff == 2'd2)
                      & write_enable_latch_ff
                      & (pwrt_ff == 32'd0);
    assign done_now = wr_ff & (wcnt_ff == 32'd1);
    assign cfg_wr_ok = adr_low_ff[7:2] == 6'd0 && adr_high_ff == 8'h00;
    assign we_arr   = done_now & ~config_space_select_ff;

    nvc_array #(.AW(AW)) u_array (
        .ref_clk_in (ref_clk_in),
        .we_in      (we_arr),
        .waddr_in   (wadr_ff),
        .wdata_in   (wdat_ff),
        .raddr_in   ((erd_ff & ~ctl_wr) ? eadr_ff : adr_low_ff),
        .rdata_out  (arr_q)
    );

    always @* begin
        cfg_ok = 1'b1;
        cfg_q  = 14'h0000;
        if (adr_high_ff != 8'h00) begin
            cfg_ok = 1'b0;
        end else if (adr_low_ff <= `NVC_CFG_UID_LAST) begin
            cfg_q = uid_ff[adr_low_ff[1:0]];
        end else if (adr_low_ff == `NVC_CFG_DEVID) begin
            cfg_q = DEV_ID;
        end else if (adr_low_ff == `NVC_CFG_WORD1) begin
            cfg_q = CFG_WORD1;
        end else if (adr_low_ff == `NVC_CFG_WORD2) begin
            cfg_q = CFG_WORD2;
        end else begin
            cfg_ok = 1'b0;
        end
    end

    // decoded in the address phase so read data stands through the data phase
    assign reg_q = (haddr_in[7:0] == `NVC_OFS_ADDR_LOW)  ? adr_low_ff :
                   (haddr_in[7:0] == `NVC_OFS_ADDR_HIGH) ? adr_high_ff :
                   (haddr_in[7:0] == `NVC_OFS_DATA_LOW)  ? dat_low_ff :
                   (haddr_in[7:0] == `NVC_OFS_DATA_HIGH) ? dat_high_ff :
                   (haddr_in[7:0] == `NVC_OFS_CONTROL)   ?
                       {pgs_ff, config_space_select_ff, 3'b000, write_enable_latch_ff, wr_ff, rd_ff} :
                   (haddr_in[7:0] == `NVC_OFS_IRQ_REQ2)  ? {3'b000, done_ff, 4'b0000} :
                   8'h00;

    always @(posedge ref_clk_in) begin
        fuse_s1_ff <= data_protect_fuse_in;
        fuse_ff    <= fuse_s1_ff;
        erd_s1_ff  <= ext_rd_in;
        erd_ff     <= erd_s1_ff;
        eadr_s1_ff <= ext_addr_in;
        eadr_ff    <= eadr_s1_ff;
        if (srst_in) begin
            ap_ff <= 1'b0;
            aw_ff <= 1'b0;
            aa_ff <= 8'h00;
            hrdata_out <= 32'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
            adr_low_ff <= {AW{1'b0}};
            adr_high_ff <= 8'h00;
            dat_low_ff <= 8'h00;
            dat_high_ff <= 8'h00;
            rd_ff <= 1'b0;
            wr_ff <= 1'b0;
            write_enable_latch_ff <= 1'b0;
            config_space_select_ff <= 1'b0;
            pgs_ff <= 1'b0;
            done_ff <= 1'b0;
            key_ff <= 2'd0;
            pwrt_ff <= PWRT_CYC;
            wcnt_ff <= 32'd0;
            wadr_ff <= {AW{1'b0}};
            wdat_ff <= 8'h00;
            uid_ff[0] <= 14'h0000;
            uid_ff[1] <= 14'h0000;
            uid_ff[2] <= 14'h0000;
            uid_ff[3] <= 14'h0000;
            ext_data_out <= 8'h00;
            write_done_out <= 1'b0;
        end else begin
            ap_ff <= bus_take;
            aw_ff <= hwrite_in;
            aa_ff <= haddr_in[7:0];
            if (bus_take && !hwrite_in) begin
                hrdata_out <= {24'h00_0000, reg_q};
            end
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
            if (pwrt_ff != 32'd0) begin
                pwrt_ff <= pwrt_ff - 32'd1;
            end
            rd_ff <= 1'b0;
            // external access denied when protected
            // array port lent to an internal read this cycle: hold
            if (erd_ff && fuse_ff && ctl_wr) begin
                ext_data_out <= ext_data_out;
            end else if (erd_ff && fuse_ff) begin
                ext_data_out <= arr_q;
            end else begin
                ext_data_out <= 8'h00;
            end
            // unlock sequence tracking; any other write breaks it
            if (unlk_wr && hwdata_in[7:0] == `NVC_KEY1) begin
                key_ff <= 2'd1;
            end else if (unlk_wr && hwdata_in[7:0] == `NVC_KEY2 && key_ff == 2'd1) begin
                key_ff <= 2'd2;
            end else if (bus_wr) begin
                key_ff <= 2'd0;
            end
            if (bus_wr && aa_ff == `NVC_OFS_ADDR_LOW) begin
                adr_low_ff <= hwdata_in[AW-1:0];
            end
            if (bus_wr && aa_ff == `NVC_OFS_ADDR_HIGH) begin
                adr_high_ff <= hwdata_in[7:0];
            end
            if (dl_wr) begin
                dat_low_ff <= hwdata_in[7:0];
            end
            if (bus_wr && aa_ff == `NVC_OFS_DATA_HIGH) begin
                dat_high_ff <= hwdata_in[7:0];
            end
            if (ctl_wr) begin
                write_enable_latch_ff <= hwdata_in[`NVC_BIT_WRITE_ENABLE_LATCH];
                config_space_select_ff <= hwdata_in[`NVC_BIT_CONFIG_SPACE_SELECT];
                pgs_ff  <= hwdata_in[`NVC_BIT_PGS];
            end
            // read strobe: data lands in the next cycle; reads ignore fuse
            if (ctl_wr && hwdata_in[`NVC_BIT_RD] && !wr_ff) begin
                rd_ff <= 1'b1;
                if (hwdata_in[`NVC_BIT_CONFIG_SPACE_SELECT]) begin
                    dat_low_ff  <= cfg_ok ? cfg_q[7:0] : 8'h00;
                    dat_high_ff <= cfg_ok ? {2'b00, cfg_q[13:8]} : 8'h00;
                end else if (!hwdata_in[`NVC_BIT_PGS]) begin
                    dat_low_ff <= arr_q;
                end
            end
            if (start_wr) begin
                wr_ff <= 1'b1;
                wcnt_ff <= WRITE_CYC;
                wadr_ff <= adr_low_ff;
                wdat_ff <= dat_low_ff;
            end else if (wr_ff) begin
                wcnt_ff <= wcnt_ff - 32'd1;
            end
            if (done_now) begin
                wr_ff <= 1'b0;
                if (config_space_select_ff && cfg_wr_ok) begin
                    uid_ff[adr_low_ff[1:0]] <= {dat_high_ff[5:0], dat_low_ff};
                end
            end
            // set wins over software clear
            if (done_now) begin
                done_ff <= 1'b1;
                write_done_out <= 1'b1;
            end else if (bus_wr && aa_ff == `NVC_OFS_IRQ_REQ2 && !hwdata_in[`NVC_BIT_DONE]) begin
                done_ff <= 1'b0;
                write_done_out <= 1'b0;
            end
        end
    end
endmodule

// ==== src/nvc_defines.vh ====
`ifndef NVC_DEFINES_VH
`define NVC_DEFINES_VH
`define NVC_OFS_ADDR_LOW   8'h00
`define NVC_OFS_ADDR_HIGH  8'h04
`define NVC_OFS_DATA_LOW   8'h08
`define NVC_OFS_DATA_HIGH  8'h0C
`define NVC_OFS_CONTROL    8'h10
`define NVC_OFS_UNLOCK     8'h14
`define NVC_OFS_IRQ_REQ2   8'h18
`define NVC_BIT_RD         0
`define NVC_BIT_WR         1
`define NVC_BIT_WRITE_ENABLE_LATCH       2
`define NVC_BIT_CONFIG_SPACE_SELECT       6
`define NVC_BIT_PGS        7
`define NVC_BIT_DONE       4
`define NVC_KEY1           8'h55
`define NVC_KEY2           8'hAA
`define NVC_CFG_UID_LAST   8'h03
`define NVC_CFG_DEVID      8'h06
`define NVC_CFG_WORD1      8'h07
`define NVC_CFG_WORD2      8'h08
`define NVC_PWRT_MS        64
`define NVC_WRITE_MS       4
`define NVC_CLK_KHZ        100000
`define NVC_PWRT_CYC       (`NVC_PWRT_MS * `NVC_CLK_KHZ)
`define NVC_WRITE_CYC      (`NVC_WRITE_MS * `NVC_CLK_KHZ)
`endif

// ==== verification/nvc_ctrl_sva.sv ====
`timescale 1ns/1ps
module nvc_ctrl_sva #(
    parameter        AW        = 8,
    parameter [31:0] PWRT_CYC  = 40,
    parameter [31:0] WRITE_CYC = 12
) (
    input wire          ref_clk_in,
    input wire          srst_in,
    input wire          hsel_in,
    input wire [31:0]   haddr_in,
    input wire [1:0]    htrans_in,
    input wire          hwrite_in,
    input wire [2:0]    hsize_in,
    input wire [31:0]   hwdata_in,
    input wire          hready_in,
    input wire [31:0]   hrdata_out,
    input wire          hreadyout_out,
    input wire          hresp_out,
    input wire          data_protect_fuse_in,
    input wire          ext_rd_in,
    input wire [AW-1:0] ext_addr_in,
    input wire [7:0]    ext_data_out,
    input wire          write_done_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    wire        addr_ph = hsel_in & htrans_in[1] & hready_in;
    wire        clr_wr  = addr_ph & hwrite_in & (haddr_in[7:0] == 8'h18);
    wire        bad_rd  = addr_ph & !hwrite_in & (haddr_in[7:0] > 8'h18);
    reg  [31:0] up_cnt_ff;
    // cycles since reset release, saturating
    always @(posedge ref_clk_in) begin
        if (srst_in)
            up_cnt_ff <= 32'h0000_0000;
        else if (up_cnt_ff < PWRT_CYC + WRITE_CYC)
            up_cnt_ff <= up_cnt_ff + 32'h0000_0001;
    end
    sequence fuse_low_s; !data_protect_fuse_in [*4]; endsequence
    sequence rd_idle_s; !ext_rd_in [*4]; endsequence
    chk_ready_high: assert property (addr_ph |-> hreadyout_out ##1 hreadyout_out)
        else $error("slave not ready");
    chk_resp_okay: assert property (!hresp_out)
        else $error("error response seen");
    chk_reset_clear: assert property ($fell(srst_in) |->
        hrdata_out == 32'h0000_0000 && !write_done_out && ext_data_out == 8'h00)
        else $error("outputs not cleared by reset");
    chk_done_sticky: assert property ($fell(write_done_out) |-> $past(clr_wr) ||
        $past(clr_wr, 2) || $past(clr_wr, 3) || $past(clr_wr, 4))
        else $error("done flag dropped without clear");
    chk_pwrt_hold: assert property (up_cnt_ff < PWRT_CYC + WRITE_CYC |-> !write_done_out)
        else $error("write completed during power-up");
    chk_unmapped_zero: assert property (bad_rd |=> hrdata_out == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_fuse_deny: assert property (fuse_low_s |=> ext_data_out == 8'h00)
        else $error("external read while protected");
    chk_ext_idle: assert property (rd_idle_s |=> ext_data_out == 8'h00)
        else $error("external data without request");
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`define CMP(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("Error %0t got %h exp %h", $time, g, e); end end
module testbench;
    logic        ref_clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        hsel_in = 1'b0;
    logic [31:0] haddr_in = 32'h0000_0000;
    logic [1:0]  htrans_in = 2'b00;
    logic        hwrite_in = 1'b0;
    logic [2:0]  hsize_in = 3'b010;
    logic [31:0] hwdata_in = 32'h0000_0000;
    logic        data_protect_fuse_in = 1'b1;
    logic        ext_rd_in = 1'b0;
    logic [7:0]  ext_addr_in = 8'h00;
    wire  [31:0] hrdata_out;
    wire         hreadyout_out;
    wire         hresp_out;
    wire  [7:0]  ext_data_out;
    wire         write_done_out;
    wire         hready_in = hreadyout_out;
    logic [31:0] rdv;
    int          n_errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    nvc_ctrl #(.PWRT_CYC(40), .WRITE_CYC(12), .DEV_ID(14'h2A5C)) dut (.*);
    always #5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            complete_run();
        end
    end
    task automatic complete_run;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge ref_clk_in);
        hsel_in <= 1'b1;
        haddr_in <= {24'h00_0000, a};
        htrans_in <= 2'b10;
        hwrite_in <= w;
        do @(posedge ref_clk_in); while (hready_in !== 1'b1);
        htrans_in <= 2'b00;
        hwdata_in <= d;
        do @(posedge ref_clk_in); while (hready_in !== 1'b1);
        rdv = hrdata_out;
    endtask
    task automatic wr(input logic [7:0] a, d);
        bus(a, 1'b1, {24'h00_0000, d});
    endtask
    task automatic rdc(input logic [7:0] a, e);
        bus(a, 1'b0, 32'h0000_0000);
        `CMP(rdv, {24'h00_0000, e})
    endtask
    task automatic keys(input logic [7:0] k1, k2, ctl);
        wr(8'h14, k1);
        wr(8'h14, k2);
        wr(8'h10, ctl);
    endtask
    task automatic commit(input logic [7:0] a, d, input logic clr);
        wr(8'h00, a);
        wr(8'h08, d);
        wr(8'h10, 8'h04);
        keys(8'h55, 8'hAA, 8'h06);
        if (clr) wr(8'h10, 8'h00);
        bus(8'h10, 1'b0, 32'h0000_0000);
        `CMP(rdv[1], 1'b1)
        for (int i = 0; i < 30 && rdv[4] !== 1'b1; i++) bus(8'h18, 1'b0, 32'h0000_0000);
        `CMP(rdv[4], 1'b1)
        repeat (4) @(posedge ref_clk_in);
        rdc(8'h18, 8'h10);
        wr(8'h18, 8'h00);
        rdc(8'h18, 8'h00);
        rdc(8'h10, clr ? 8'h00 : 8'h04);
    endtask
    initial begin
        repeat (12) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        rdc(8'h10, 8'h00);
        wr(8'h00, 8'h05);
        wr(8'h08, 8'hA5);
        wr(8'h10, 8'h04);
        keys(8'h55, 8'hAA, 8'h06);
        rdc(8'h10, 8'h04);
        $display("test power-up done");
        repeat (40) @(posedge ref_clk_in);
        keys(8'hAA, 8'h55, 8'h06);
        rdc(8'h10, 8'h04);
        wr(8'h10, 8'h00);
        keys(8'h55, 8'hAA, 8'h02);
        rdc(8'h10, 8'h00);
        $display("test refusal done");
        commit(8'h05, 8'hA5, 1'b0);
        commit(8'h06, 8'h3C, 1'b1);
        $display("test write done");
        wr(8'h08, 8'h00);
        wr(8'h00, 8'h05);
        wr(8'h10, 8'h01);
        rdc(8'h08, 8'hA5);
        rdc(8'h08, 8'hA5);
        wr(8'h00, 8'h06);
        wr(8'h10, 8'h01);
        rdc(8'h08, 8'h3C);
        data_protect_fuse_in <= 1'b0;
        ext_rd_in <= 1'b1;
        ext_addr_in <= 8'h05;
        repeat (6) @(posedge ref_clk_in);
        `CMP(ext_data_out, 8'h00)
        wr(8'h00, 8'h05);
        wr(8'h10, 8'h01);
        rdc(8'h08, 8'hA5);
        data_protect_fuse_in <= 1'b1;
        repeat (6) @(posedge ref_clk_in);
        `CMP(ext_data_out, 8'hA5)
        $display("test read done");
        wr(8'h04, 8'h00);
        wr(8'h00, 8'h06);
        wr(8'h10, 8'h41);
        rdc(8'h08, 8'h5C);
        rdc(8'h0C, 8'h2A);
        wr(8'h00, 8'h05);
        wr(8'h10, 8'h41);
        rdc(8'h08, 8'h00);
        rdc(8'h0C, 8'h00);
        rdc(8'h1C, 8'h00);
        $display("test config done");
        complete_run();
    end
endmodule
bind nvc_ctrl nvc_ctrl_sva #(.AW(AW), .PWRT_CYC(PWRT_CYC), .WRITE_CYC(WRITE_CYC)) u_sva (.*);
